//--- src/cawp_top.sv
// Counter array with 8/9/10/11-bit PWM modules and mode register
`timescale 1ns/1ps
`default_nettype none
`include "cawp_cfg.svh"

module cawp_top (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    // Register port
    input  wire cawp_pkg::cawp_sfr_req_t sfr_req,
    output logic [7:0]                 sfr_rdata,
    // Tick sources
    input  wire logic                  timer0_overflow,
    input  wire logic                  cpu_idle,
    input  wire cawp_pkg::cawp_pins_t  pins,
    // Outputs
    output logic [2:0]                 module_output_pin,
    output logic                       counter_irq,
    output logic                       watchdog_reset
);
    import cawp_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Decode helpers
    function automatic logic [2:0] cmp_hit(input logic [7:0] a, input logic high);
        logic [2:0] h;
        h = 3'h0;
        for (int i = 0; i < NUM_MOD; i++)
            h[i] = (a == 8'(`CAWP_ADDR_CMP_LOW0 + 2 * i + (high ? 1 : 0)));
        return h;
    endfunction : cmp_hit

    function automatic logic [10:0] len_mask(input logic [1:0] clen);
        case (clen)
            2'h0:    return 11'h0ff;
            2'h1:    return 11'h1ff;
            2'h2:    return 11'h3ff;
            default: return 11'h7ff;
        endcase
    endfunction : len_mask

    ////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]  mode_reg;
    logic        run_reg;
    logic        ovf_flag_reg;
    logic [2:0]  match_flag_reg;
    logic        rsel_reg;
    logic        cyc_ovf_reg;
    logic [1:0]  clen_reg;
    logic [2:0]  cmp_en_reg;
    logic [2:0]  flag_en_reg;
    logic [2:0]  pwm_reg;
    logic [15:0] count_reg;
    logic [15:0] count_next;

    logic        idle_sync1_reg;
    logic        idle_sync2_reg;
    logic        tick;
    logic [10:0] mask;
    logic        wrap;
    logic        wdt_on;
    logic        wr;
    logic [2:0]  wr_low;
    logic [2:0]  wr_high;
    logic [2:0]  low_hit;
    logic [2:0]  high_hit;
    logic [2:0]  match;
    logic [2:0]  pin;
    logic [15:0] cmp_val [NUM_MOD];
    logic [15:0] rld_val [NUM_MOD];
    logic [7:0]  rd_next;

    assign wr       = sfr_req.wr;
    assign low_hit  = cmp_hit(sfr_req.addr, 1'b0);
    assign high_hit = cmp_hit(sfr_req.addr, 1'b1);
    assign wr_low   = wr ? low_hit : 3'h0;
    assign wr_high  = wr ? high_hit : 3'h0;
    assign wdt_on   = mode_reg[`CAWP_MODE_WDT_BIT];
    assign mask     = len_mask(clen_reg);
    assign count_next = count_reg + 16'h0001;
    assign wrap     = ((count_reg[10:0] & mask) == mask);

    ////////////////////////////////////////////////////////////////
    // Idle level from another domain
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            idle_sync1_reg <= 1'b0;
            idle_sync2_reg <= 1'b0;
        end else begin
            idle_sync1_reg <= cpu_idle;
            idle_sync2_reg <= idle_sync1_reg;
        end
    end

    cawp_timebase u_timebase (
        .core_clk        (core_clk),
        .reset_n         (reset_n),
        .timebase_select (cawp_timebase_t'(mode_reg[3:1])),
        .run             (run_reg && !(idle_sync2_reg && mode_reg[`CAWP_MODE_IDLE_BIT])),
        .timer0_overflow (timer0_overflow),
        .pins            (pins),
        .tick            (tick)
    );

    ////////////////////////////////////////////////////////////////
    // Array counter
    always_ff @(posedge core_clk) begin
        if (!reset_n)
            count_reg <= 16'h0000;
        else if (tick)
            count_reg <= count_next;
    end

    ////////////////////////////////////////////////////////////////
    // Mode register; lock holds the watchdog on until reset
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            mode_reg <= `CAWP_MODE_RESET;
        end else if (wr && sfr_req.addr == `CAWP_ADDR_MODE) begin
            if (wdt_on) begin
                if (!mode_reg[`CAWP_MODE_LOCK_BIT])
                    mode_reg[`CAWP_MODE_WDT_BIT] <= sfr_req.wdata[`CAWP_MODE_WDT_BIT];
            end else begin
                mode_reg    <= sfr_req.wdata;
                mode_reg[4] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Control and wide PWM registers; hardware set beats clear
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            run_reg        <= 1'b0;
            ovf_flag_reg   <= 1'b0;
            match_flag_reg <= 3'h0;
            rsel_reg       <= 1'b0;
            cyc_ovf_reg    <= 1'b0;
            clen_reg       <= 2'h0;
        end else begin
            if (wr && sfr_req.addr == `CAWP_ADDR_CONTROL) begin
                run_reg        <= sfr_req.wdata[`CAWP_CTL_RUN_BIT];
                ovf_flag_reg   <= sfr_req.wdata[`CAWP_CTL_OVF_BIT];
                match_flag_reg <= sfr_req.wdata[2:0];
            end
            if (wr && sfr_req.addr == `CAWP_ADDR_WIDE_PWM) begin
                rsel_reg    <= sfr_req.wdata[`CAWP_WP_RSEL_BIT];
                cyc_ovf_reg <= sfr_req.wdata[`CAWP_WP_CYCOVF_BIT];
                clen_reg    <= sfr_req.wdata[1:0];
            end
            if (tick && count_reg == 16'hffff)
                ovf_flag_reg <= 1'b1;
            if (tick && wrap)
                cyc_ovf_reg <= 1'b1;
            for (int i = 0; i < NUM_MOD; i++)
                if (match[i] && flag_en_reg[i])
                    match_flag_reg[i] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Module mode registers
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cmp_en_reg  <= 3'h0;
            flag_en_reg <= 3'h0;
            pwm_reg     <= 3'h0;
        end else begin
            for (int i = 0; i < NUM_MOD; i++) begin
                if (wr && sfr_req.addr == 8'(`CAWP_ADDR_MOD_MODE0 + i)) begin
                    cmp_en_reg[i]  <= sfr_req.wdata[`CAWP_MM_CMPEN_BIT];
                    flag_en_reg[i] <= sfr_req.wdata[`CAWP_MM_FLAGEN_BIT];
                    pwm_reg[i]     <= sfr_req.wdata[`CAWP_MM_PWM_BIT];
                end
                if (wr_low[i])
                    cmp_en_reg[i] <= 1'b0;
                if (wr_high[i])
                    cmp_en_reg[i] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Compare modules
    for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
        cawp_channel u_channel (
            .core_clk      (core_clk),
            .reset_n       (reset_n),
            .wr_low        (wr_low[g]),
            .wr_high       (wr_high[g]),
            .sel_reload    (rsel_reg),
            .wdata         (sfr_req.wdata),
            .tick          (tick),
            .wrap          (wrap),
            .count_low     (count_next[10:0] & mask),
            .mask          (mask),
            .comp_en       (cmp_en_reg[g]),
            .pwm_en        (pwm_reg[g]),
            .compare_value (cmp_val[g]),
            .reload_value  (rld_val[g]),
            .pin           (pin[g]),
            .match         (match[g])
        );
    end

    ////////////////////////////////////////////////////////////////
    // Pins, interrupt and watchdog
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            module_output_pin <= 3'h0;
            counter_irq       <= 1'b0;
            watchdog_reset    <= 1'b0;
        end else begin
            module_output_pin <= pin;
            // Module 2 pin is held low while it times the watchdog
            if (wdt_on)
                module_output_pin[`CAWP_WDT_MODULE] <= 1'b0;
            counter_irq    <= ovf_flag_reg && mode_reg[`CAWP_MODE_IRQ_BIT];
            watchdog_reset <= wdt_on && tick &&
                              count_next[15:8] == cmp_val[`CAWP_WDT_MODULE][15:8];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read data
    always_comb begin
        rd_next = 8'h00;
        if (sfr_req.addr == `CAWP_ADDR_MODE)
            rd_next = mode_reg;
        else if (sfr_req.addr == `CAWP_ADDR_CONTROL)
            rd_next = {ovf_flag_reg, run_reg, 3'h0, match_flag_reg};
        else if (sfr_req.addr == `CAWP_ADDR_WIDE_PWM)
            rd_next = {rsel_reg, 1'b0, cyc_ovf_reg, 3'h0, clen_reg};
        for (int i = 0; i < NUM_MOD; i++) begin
            if (sfr_req.addr == 8'(`CAWP_ADDR_MOD_MODE0 + i))
                rd_next = {1'b0, cmp_en_reg[i], 2'h0, flag_en_reg[i], 1'b0, pwm_reg[i], 1'b0};
            if (low_hit[i])
                rd_next = rsel_reg ? rld_val[i][7:0] : cmp_val[i][7:0];
            if (high_hit[i])
                rd_next = rsel_reg ? rld_val[i][15:8] : cmp_val[i][15:8];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n)
            sfr_rdata <= `CAWP_BYTE_RESET;
        else if (sfr_req.rd)
            sfr_rdata <= rd_next;
    end

endmodule : cawp_top
`default_nettype wire

//--- include/cawp_cfg.svh
// Constants for the wide PWM counter array
`ifndef CAWP_CFG_SVH
`define CAWP_CFG_SVH

// Register addresses
`define CAWP_ADDR_MODE       8'hd9
`define CAWP_ADDR_CONTROL    8'hd8
`define CAWP_ADDR_WIDE_PWM   8'hd7
`define CAWP_ADDR_MOD_MODE0  8'hda
`define CAWP_ADDR_CMP_LOW0   8'he9

// Reset values
`define CAWP_MODE_RESET      8'h40
`define CAWP_BYTE_RESET      8'h00

// Mode register fields
`define CAWP_MODE_IDLE_BIT   7
`define CAWP_MODE_WDT_BIT    6
`define CAWP_MODE_LOCK_BIT   5
`define CAWP_MODE_TB_LSB     1
`define CAWP_MODE_IRQ_BIT    0

// Control register fields
`define CAWP_CTL_OVF_BIT     7
`define CAWP_CTL_RUN_BIT     6

// Wide PWM control fields
`define CAWP_WP_RSEL_BIT     7
`define CAWP_WP_CYCOVF_BIT   5
`define CAWP_WP_CLEN_LSB     0

// Module mode fields
`define CAWP_MM_CMPEN_BIT    6
`define CAWP_MM_FLAGEN_BIT   3
`define CAWP_MM_PWM_BIT      1

// Timebase divisions and watchdog module
`define CAWP_DIV_SLOW        4'd11
`define CAWP_DIV_FAST        4'd3
`define CAWP_DIV_EXT         3'd7
`define CAWP_WDT_MODULE      2

`endif

//--- include/cawp_pkg.sv
// Types for the wide PWM counter array
package cawp_pkg;

    localparam int NUM_MOD = 3;

    typedef enum logic [2:0] {
        CAWP_TB_SYS12  = 3'b000,
        CAWP_TB_SYS4   = 3'b001,
        CAWP_TB_T0OVF  = 3'b010,
        CAWP_TB_EXTIN  = 3'b011,
        CAWP_TB_SYS    = 3'b100,
        CAWP_TB_EXT8   = 3'b101,
        CAWP_TB_RTC8   = 3'b110,
        CAWP_TB_RSVD   = 3'b111
    } cawp_timebase_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } cawp_sfr_req_t;

    typedef struct packed {
        logic ext_count;
        logic ext_clk;
        logic rtc_clk;
    } cawp_pins_t;

endpackage : cawp_pkg

//--- src/cawp_timebase.sv
// Timebase tick generator for the counter array
`timescale 1ns/1ps
`default_nettype none
`include "cawp_cfg.svh"

module cawp_timebase (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    reset_n,
    // Control
    input  wire cawp_pkg::cawp_timebase_t timebase_select,
    input  wire logic                    run,
    input  wire logic                    timer0_overflow,
    // Pins
    input  wire cawp_pkg::cawp_pins_t    pins,
    // Tick out
    output logic                         tick
);
    import cawp_pkg::*;

    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] last_reg;
    logic [3:0] pre_reg;
    logic [2:0] ext_div_reg;
    logic [2:0] rtc_div_reg;
    logic       cnt_fall;
    logic       ext_rise;
    logic       rtc_rise;

    ////////////////////////////////////////////////////////////////
    // Pins pass two flops; edges are seen only on the second
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            last_reg  <= 3'h0;
        end else begin
            sync1_reg <= {pins.ext_count, pins.ext_clk, pins.rtc_clk};
            sync2_reg <= sync1_reg;
            last_reg  <= sync2_reg;
        end
    end

    assign cnt_fall = last_reg[2] & ~sync2_reg[2];
    assign ext_rise = ~last_reg[1] & sync2_reg[1];
    assign rtc_rise = ~last_reg[0] & sync2_reg[0];

    ////////////////////////////////////////////////////////////////
    // Dividers
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pre_reg     <= 4'h0;
            ext_div_reg <= 3'h0;
            rtc_div_reg <= 3'h0;
        end else begin
            if ((timebase_select == CAWP_TB_SYS12 && pre_reg == `CAWP_DIV_SLOW) ||
                (timebase_select == CAWP_TB_SYS4 && pre_reg == `CAWP_DIV_FAST))
                pre_reg <= 4'h0;
            else
                pre_reg <= pre_reg + 4'h1;
            if (ext_rise)
                ext_div_reg <= ext_div_reg + 3'h1;
            if (rtc_rise)
                rtc_div_reg <= rtc_div_reg + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Source select
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            tick <= 1'b0;
        end else if (!run) begin
            tick <= 1'b0;
        end else begin
            case (timebase_select)
                CAWP_TB_SYS12: tick <= (pre_reg == `CAWP_DIV_SLOW);
                CAWP_TB_SYS4:  tick <= (pre_reg == `CAWP_DIV_FAST);
                CAWP_TB_T0OVF: tick <= timer0_overflow;
                CAWP_TB_EXTIN: tick <= cnt_fall;
                CAWP_TB_SYS:   tick <= 1'b1;
                CAWP_TB_EXT8:  tick <= ext_rise && ext_div_reg == `CAWP_DIV_EXT;
                CAWP_TB_RTC8:  tick <= rtc_rise && rtc_div_reg == `CAWP_DIV_EXT;
                default:       tick <= 1'b0;
            endcase
        end
    end

endmodule : cawp_timebase
`default_nettype wire

//--- src/cawp_channel.sv
// One compare module in wide PWM mode
`timescale 1ns/1ps
`default_nettype none
`include "cawp_cfg.svh"

module cawp_channel (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // Byte writes
    input  wire logic        wr_low,
    input  wire logic        wr_high,
    input  wire logic        sel_reload,
    input  wire logic [7:0]  wdata,
    // Counter events
    input  wire logic        tick,
    input  wire logic        wrap,
    input  wire logic [10:0] count_low,
    input  wire logic [10:0] mask,
    input  wire logic        comp_en,
    input  wire logic        pwm_en,
    // Results
    output logic [15:0]      compare_value,
    output logic [15:0]      reload_value,
    output logic             pin,
    output logic             match
);
    import cawp_pkg::*;

    logic [15:0] eff;
    logic        hit;

    // On wrap the freshly reloaded value is the one compared
    assign eff = wrap ? reload_value : compare_value;
    assign hit = tick && ((eff[10:0] & mask) == count_low);

    ////////////////////////////////////////////////////////////////
    // Compare and reload storage
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            compare_value <= 16'h0000;
            reload_value  <= 16'h0000;
        end else begin
            if (wr_low && sel_reload)
                reload_value[7:0] <= wdata;
            if (wr_high && sel_reload)
                reload_value[15:8] <= wdata;
            if (tick && wrap)
                compare_value <= reload_value;
            else if (wr_low && !sel_reload)
                compare_value[7:0] <= wdata;
            else if (wr_high && !sel_reload)
                compare_value[15:8] <= wdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Output pin; match wins at zero so compare 0 gives full duty
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pin   <= 1'b0;
            match <= 1'b0;
        end else begin
            match <= hit && comp_en;
            if (!comp_en || !pwm_en)
                pin <= 1'b0;
            else if (hit)
                pin <= 1'b1;
            else if (tick && wrap)
                pin <= 1'b0;
        end
    end

endmodule : cawp_channel
`default_nettype wire

//--- dv/cawp_chk.sv
// Port checker for the wide PWM counter array
`timescale 1ns/1ps
`default_nettype none
module cawp_chk (
    // Clock and reset
    input wire logic                    core_clk,
    input wire logic                    reset_n,
    // Register port
    input wire cawp_pkg::cawp_sfr_req_t sfr_req,
    input wire logic [7:0]              sfr_rdata,
    // Outputs
    input wire logic [2:0]              module_output_pin,
    input wire logic                    counter_irq,
    input wire logic                    watchdog_reset
);
    import cawp_pkg::*;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    logic [7:0] mode_q;
    logic [7:0] mm0_q;
    logic       en0;
    assign en0 = mm0_q[6] & mm0_q[1];
    ////////////////////////////////////////////////////////////////////////////
    // Mirror of the mode register; under the watchdog only bit 6 may move
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            mode_q <= 8'h40;
        end else if (sfr_req.wr && sfr_req.addr == 8'hd9 && !mode_q[6]) begin
            mode_q <= sfr_req.wdata & 8'hef;
        end else if (sfr_req.wr && sfr_req.addr == 8'hd9 && !mode_q[5]) begin
            mode_q[6] <= sfr_req.wdata[6];
        end
    end
    // Mirror of module 0 mode bits
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            mm0_q <= 8'h00;
        end else if (sfr_req.wr && sfr_req.addr == 8'hda) begin
            mm0_q <= sfr_req.wdata & 8'h4a;
        end else if (sfr_req.wr && (sfr_req.addr == 8'he9 || sfr_req.addr == 8'hea)) begin
            mm0_q[6] <= sfr_req.addr[1];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    wdt_pin_low_a : assert property (
        mode_q[6] [*3] |-> !module_output_pin[2]) else $error("module 2 pin active under watchdog");
    wdt_gate_a : assert property (
        watchdog_reset |-> $past(mode_q[6])) else $error("watchdog pulse while disabled");
    mode_read_a : assert property (
        sfr_req.rd && sfr_req.addr == 8'hd9 |=> sfr_rdata == $past(mode_q)) else $error("mode read wrong");
    irq_masked_a : assert property (
        !mode_q[0] [*2] |-> !counter_irq) else $error("masked overflow interrupt raised");
    mm_read_a : assert property (
        sfr_req.rd && sfr_req.addr == 8'hda |=> sfr_rdata == $past(mm0_q)) else $error("module mode read wrong");
    pin_off_a : assert property (
        !en0 [*4] |-> !module_output_pin[0]) else $error("disabled module output high");
    pin_rise_a : assert property (
        $rose(module_output_pin[0]) |-> $past(en0, 2)) else $error("output rose while disabled");
    rdata_hold_a : assert property (
        !sfr_req.rd |=> $stable(sfr_rdata)) else $error("read data moved without read");
    unmapped_rd_a : assert property (
        sfr_req.rd && sfr_req.addr == 8'h00 |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
endmodule : cawp_chk

bind cawp_top cawp_chk i_chk (.core_clk(core_clk), .reset_n(reset_n), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .module_output_pin(module_output_pin), .counter_irq(counter_irq),
    .watchdog_reset(watchdog_reset));
`default_nettype wire

//--- dv/cawp_load.sv
// Load model measuring high time and period of a PWM output
`timescale 1ns/1ps
`default_nettype none
module cawp_load (
    // Clock
    input  wire logic        core_clk,
    // Observed output
    input  wire logic        pin,
    // Measurement control
    input  wire logic        arm,
    input  wire logic [15:0] window,
    output logic             done,
    output logic [31:0]      meas
);
    logic [15:0] cyc = 16'h0000;
    logic [15:0] hi = 16'h0000;
    logic [15:0] last_fall = 16'h0000;
    logic [15:0] per = 16'h0000;
    logic        busy = 1'b0;
    logic        fin = 1'b0;
    logic        pin_d = 1'b0;
    initial done = 1'b0;
    initial meas = 32'h0000_0000;
    // Window of whole periods gives an exact high count at any start phase
    always @(posedge core_clk) begin
        pin_d <= pin;
        fin <= 1'b0;
        done <= fin;
        if (fin) begin
            meas <= {per, hi};
        end
        if (arm) begin
            cyc <= 16'h0001;
            hi <= 16'h0000;
            last_fall <= 16'h0000;
            per <= 16'h0000;
            busy <= 1'b1;
        end else if (busy) begin
            hi <= hi + 16'(pin);
            if (pin_d && !pin) begin
                if (last_fall != 16'h0000) per <= cyc - last_fall;
                last_fall <= cyc;
            end
            if (cyc == window) begin
                busy <= 1'b0;
                fin <= 1'b1;
            end
            cyc <= cyc + 16'h0001;
        end
    end
endmodule : cawp_load
`default_nettype wire

//--- dv/cawp_tb_top.sv
// Self-checking bench for the wide PWM counter array
`timescale 1ns/1ps
`default_nettype none
module cawp_tb_top;
    import cawp_pkg::*;
    localparam int DLY = 5;
    localparam int TB_DIV [7] = '{12, 4, 3, 6, 1, 16, 16};
    logic          core_clk;
    logic          reset_n;
    cawp_sfr_req_t sfr_req;
    logic [7:0]    sfr_rdata;
    logic          timer0_overflow;
    logic          cpu_idle;
    cawp_pins_t    pins;
    logic [2:0]    module_output_pin;
    logic          counter_irq;
    logic          watchdog_reset;
    logic          arm;
    logic [15:0]   window;
    logic          meas_done;
    logic [31:0]   meas;
    logic [31:0]   exp_q [$];
    logic          rd_pend;
    logic [15:0]   cv;
    int            per;
    int            phase;
    int            failures;
    int            num_checks;
    cawp_top i_dut (.core_clk(core_clk), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .timer0_overflow(timer0_overflow), .cpu_idle(cpu_idle), .pins(pins),
        .module_output_pin(module_output_pin), .counter_irq(counter_irq), .watchdog_reset(watchdog_reset));
    cawp_load i_load (.core_clk(core_clk), .pin(module_output_pin[0]), .arm(arm), .window(window),
        .done(meas_done), .meas(meas));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Slow sources: timer0 every 3 cycles, count input falls every 6, clocks rise every 2
    always @(posedge core_clk) begin
        #DLY;
        phase = phase + 1;
        timer0_overflow = (phase % 3 == 0);
        pins.ext_count = (phase % 6) < 3;
        pins.ext_clk = (phase % 2 == 0);
        pins.rtc_clk = (phase % 2 == 1);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    // Results are compared oldest-first as they appear
    always @(posedge core_clk) begin
        if (rd_pend || meas_done === 1'b1) begin
            check(rd_pend ? {24'h0, sfr_rdata} : meas, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
        end
        rd_pend = sfr_req.rd;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #DLY;
    endtask : idle
    task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
        sfr_req = '{addr: a, wr: w, rd: !w, wdata: d};
        idle(1);
        sfr_req = '0;
        idle(1);
    endtask : acc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        acc(a, 1'b0, 8'h00);
    endtask : rd
    task automatic measure(input int w, input logic [31:0] e);
        int n;
        exp_q.push_back(e);
        window = 16'(w);
        arm = 1'b1;
        idle(1);
        arm = 1'b0;
        n = 0;
        while (meas_done !== 1'b1 && n < w + 10) begin
            idle(1);
            n++;
        end
        if (n >= w + 10) begin
            failures++;
            wrap_up();
        end
        idle(1);
    endtask : measure
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        reset_n = 1'b0;
        sfr_req = '0;
        timer0_overflow = 1'b0;
        cpu_idle = 1'b0;
        pins = '0;
        arm = 1'b0;
        window = 16'h0000;
        rd_pend = 1'b0;
        phase = 0;
        failures = 0;
        num_checks = 0;
        void'($urandom(38139));
        idle(4);
        reset_n = 1'b1;
        rd(8'hd9, 8'h40);
        rd(8'h00, 8'h00);
        wr(8'hd8, 8'h40);
        n = 0;
        while (watchdog_reset !== 1'b1 && n < 200) begin
            idle(1);
            n++;
        end
        check({31'h0, watchdog_reset}, 32'h1);
        if (n >= 200) wrap_up();
        idle(1);
        wr(8'hd9, 8'hff);
        rd(8'hd9, 8'h40);
        wr(8'hd9, 8'h00);
        rd(8'hd9, 8'h00);
        wr(8'hd9, 8'h39);
        rd(8'hd9, 8'h29);
        wr(8'hd8, 8'hc0);
        check({31'h0, counter_irq}, 32'h1);
        wr(8'hd9, 8'h28);
        check({31'h0, counter_irq}, 32'h0);
        wr(8'hd8, 8'h40);
        $display("test mode register done");
        wr(8'hd7, 8'h01);
        wr(8'hda, 8'h4a);
        wr(8'he9, 8'h00);
        wr(8'hea, 8'h01);
        rd(8'hda, 8'h4a);
        idle(600);
        rd(8'hd8, 8'h41);
        wr(8'hda, 8'h42);
        wr(8'hd8, 8'h40);
        idle(600);
        rd(8'hd8, 8'h40);
        wr(8'he9, 8'h00);
        rd(8'hda, 8'h02);
        wr(8'hea, 8'h00);
        rd(8'hda, 8'h42);
        $display("test match flag done");
        wr(8'hd8, 8'h00);
        cv = 16'($urandom % 512);
        wr(8'hd7, 8'h81);
        wr(8'he9, cv[7:0]);
        wr(8'hea, cv[15:8]);
        wr(8'hd7, 8'h01);
        wr(8'he9, 8'h55);
        wr(8'hea, 8'h01);
        rd(8'he9, 8'h55);
        rd(8'hea, 8'h01);
        wr(8'hd7, 8'h81);
        rd(8'he9, cv[7:0]);
        rd(8'hea, cv[15:8]);
        wr(8'hd8, 8'h40);
        idle(530);
        rd(8'hd7, 8'ha1);
        wr(8'hd7, 8'h01);
        rd(8'he9, cv[7:0]);
        rd(8'hea, cv[15:8]);
        $display("test reload path done");
        for (int k = 1; k < 4; k++) begin
            per = 256 << k;
            cv = 16'($urandom % (per - 1) + 1);
            wr(8'hd7, 8'h80 | 8'(k));
            wr(8'he9, cv[7:0]);
            wr(8'hea, cv[15:8]);
            idle(per + 8);
            measure(2 * per, {16'(per), 16'(2 * (per - int'(cv)))});
        end
        wr(8'hd7, 8'h81);
        wr(8'he9, 8'h00);
        wr(8'hea, 8'h00);
        idle(520);
        measure(1024, {16'h0000, 16'h0400});
        wr(8'he9, 8'h80);
        idle(4);
        check({29'h0, module_output_pin}, 32'h0);
        measure(1024, 32'h0000_0000);
        $display("test duty cycle done");
        wr(8'hea, 8'h00);
        wr(8'hd7, 8'h80);
        for (int t = 0; t < 7; t++) begin
            wr(8'hd9, 8'(t << 1));
            idle(256 * TB_DIV[t] + 16);
            measure(512 * TB_DIV[t], {16'(256 * TB_DIV[t]), 16'(256 * TB_DIV[t])});
        end
        $display("test timebase done");
        wrap_up();
    end
endmodule : cawp_tb_top
`default_nettype wire
